// ---- alsc_core.sv ----
// request checker and status reporter for an ascii multidrop link
// assumes a uart on clk delivering characters with a parity error flag,
// and a request parser / controller core supplying status levels
`timescale 1ns/1ps
module alsc_core
  import alsc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // incoming request characters
  input wire logic [7:0] rx_char,
  input wire logic rx_valid,
  input wire logic rx_parity_err,
  output logic rx_ready,
  // verdict levels from the parser / controller core
  input wire logic op_unsupported,
  input wire logic data_invalid,
  input wire logic db_busy,
  input wire logic state_illegal,
  input wire logic tuning_active,
  input wire logic unable_now,
  // status-change event pulses, one bit per cause
  input wire logic [EVT_W-1:0] change_evt,
  // pulse: host wrote parameter 255
  input wire logic change_clear,
  // per request verdict
  output logic req_done,
  output logic req_execute,
  output logic req_checksummed,
  output logic [7:0] req_status,
  output logic [7:0] ctl_status,
  output logic change_flag,
  // response status characters toward the transmitter
  output logic [7:0] tx_char,
  output logic tx_valid,
  input wire logic tx_ready
);
  // one-hot states
  typedef enum logic [1:0] {
    ST_RECV = 2'b01,
    ST_EMIT = 2'b10
  } alsc_state_e;

  alsc_state_e state;
  alsc_state_e next_state;
  // running sum of the message characters so far, cr excluded
  logic [7:0] sum;
  // sum at start of the current field, commas included
  logic [7:0] field_sum;
  // characters in the message and in the current field
  logic [6:0] msg_len;
  logic [6:0] fld_len;
  // commas seen
  logic [3:0] commas;
  // last four characters of the current field
  logic [27:0] tail;
  // per message error marks
  logic par_bad;
  logic fmt_bad;
  logic ck_fmt;
  // cr seen, waiting for lf
  logic saw_cr;
  // character being taken
  logic take;
  logic [6:0] ch;
  // end of a well framed message
  logic msg_end;
  // verdict computed at message end
  logic [7:0] next_req;
  logic [6:0] next_base;
  logic ck_ok;
  logic [4:0] hi_dig;
  logic [4:0] lo_dig;
  // response emission
  logic [1:0] emit_idx;
  logic [7:0] emit_char;
  logic buf_in_ready;

  // hex digit to {valid, nibble}
  function automatic logic [4:0] hex_val(input logic [6:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 7'h30 && c <= 7'h39) begin
      r = {1'b1, 4'(c - 7'h30)};
    end else if (c >= 7'h41 && c <= 7'h46) begin
      r = {1'b1, 4'(c - 7'h37)};
    end else if (c >= 7'h61 && c <= 7'h66) begin
      r = {1'b1, 4'(c - 7'h57)};
    end
    return r;
  endfunction

  // nibble to upper-case ascii hex
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    logic [7:0] r;
    r = (n < 4'ha) ? (8'h30 + 8'(n)) : (8'h37 + 8'(n));
    return r;
  endfunction

  // characters are refused until the last response character has entered the buffer
  assign rx_ready = (state == ST_RECV);
  assign take = rx_valid && rx_ready;
  // parity bit ignored everywhere
  // parity stripped
  assign ch = rx_char[6:0];
  assign msg_end = take && saw_cr && (ch == CH_LF);

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_RECV;
    end else begin
      state <= next_state;
    end
  end

  // receive until framed, then emit four characters
  always_comb begin
    next_state = state;
    case (state)
      ST_RECV: begin
        if (msg_end) begin
          next_state = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (buf_in_ready && emit_idx == RESP_LAST) begin
          next_state = ST_RECV;
        end
      end
      default: begin
        next_state = ST_RECV;
      end
    endcase
  end

  // running checksum and field snapshot
  always_ff @(posedge clk) begin
    // a cr followed by anything clears the message, framed or broken
    if (srst || (take && saw_cr)) begin
      sum <= SUM_RST;
      field_sum <= SUM_RST;
    end else if (take && !saw_cr && ch != CH_CR) begin
      sum <= sum + {1'b0, ch};
      if (ch == CH_COMMA) begin
        field_sum <= sum + {1'b0, ch};
      end
    end
  end

  // field tracking: lengths, commas and tail characters
  always_ff @(posedge clk) begin
    if (srst || (take && saw_cr)) begin
      msg_len <= LEN_RST;
      fld_len <= LEN_RST;
      commas <= 4'h0;
      tail <= 28'h0;
    end else if (take && !saw_cr && ch != CH_CR) begin
      if (msg_len != MSG_MAX) begin
        msg_len <= msg_len + 7'h1;
      end
      if (ch == CH_COMMA) begin
        fld_len <= LEN_RST;
        tail <= 28'h0;
        if (commas != 4'hf) begin
          commas <= commas + 4'h1;
        end
      end else begin
        if (fld_len != MSG_MAX) begin
          fld_len <= fld_len + 7'h1;
        end
        tail <= {tail[20:0], ch};
      end
    end
  end

  // format identifier of the checksum variant
  always_ff @(posedge clk) begin
    if (srst || (take && saw_cr)) begin
      ck_fmt <= 1'b0;
    end else if (take && !saw_cr && ch == CH_COMMA && commas == FMT_FIELD) begin
      ck_fmt <= (fld_len == 7'h4) && (tail == FMT_CKSUM);
    end
  end

  // parity and format faults, sticky within the message
  always_ff @(posedge clk) begin
    if (srst || (take && saw_cr)) begin
      par_bad <= 1'b0;
      fmt_bad <= 1'b0;
    end else if (take) begin
      if (rx_parity_err) begin
        par_bad <= 1'b1;
      end
      // control characters other than the terminators, or overlong
      if (!saw_cr && ch != CH_CR && (ch < CH_SPACE || ch == CH_DEL)) begin
        fmt_bad <= 1'b1;
      end
      if (!saw_cr && ch != CH_CR && msg_len == MSG_MAX) begin
        fmt_bad <= 1'b1;
      end
    end
  end

  // cr / lf framing; a broken pair drops the whole message
  always_ff @(posedge clk) begin
    if (srst || (take && saw_cr)) begin
      saw_cr <= 1'b0;
    end else if (take) begin
      // cr must be followed by lf
      saw_cr <= !saw_cr && (ch == CH_CR);
    end
  end

  // checksum digits are the last two characters of the final field
  assign hi_dig = hex_val(tail[13:7]);
  assign lo_dig = hex_val(tail[6:0]);
  // high nibble first, sum before field
  assign ck_ok = ({hi_dig[3:0], lo_dig[3:0]} == field_sum);

  // request status verdict, first failing check wins
  always_comb begin
    next_req = REQ_OK;
    if (par_bad) begin
      next_req = REQ_CHECKSUM;
    end else if (fmt_bad || commas < MIN_COMMAS) begin
      next_req = REQ_FORMAT;
    end else if (ck_fmt && (fld_len != 7'h2 || !hi_dig[4] || !lo_dig[4])) begin
      // malformed checksum field is a format fault
      next_req = REQ_FORMAT;
    end else if (ck_fmt && !ck_ok) begin
      next_req = REQ_CHECKSUM;
    end else if (op_unsupported) begin
      next_req = REQ_UNSUPPORTED;
    end else begin
      next_req = REQ_OK;
    end
  end

  // controller base code, most pressing condition first
  always_comb begin
    next_base = CTL_OK;
    if (unable_now) begin
      next_base = CTL_UNABLE;
    end else if (tuning_active) begin
      next_base = CTL_TUNING;
    end else if (state_illegal) begin
      next_base = CTL_ILLEGAL;
    end else if (db_busy) begin
      next_base = CTL_BUSY;
    end else if (data_invalid) begin
      next_base = CTL_BAD_DATA;
    end else begin
      next_base = CTL_OK;
    end
  end

  // sticky status-change flag; a new event beats a clear
  always_ff @(posedge clk) begin
    if (srst) begin
      change_flag <= 1'b0;
    end else if (|change_evt) begin
      change_flag <= 1'b1;
    end else if (change_clear) begin
      change_flag <= 1'b0;
    end
  end

  // latched verdict of the last framed request
  always_ff @(posedge clk) begin
    if (srst) begin
      req_status <= REQ_OK;
      ctl_status <= 8'h00;
      req_checksummed <= 1'b0;
    end else if (msg_end) begin
      req_status <= next_req;
      ctl_status <= {change_flag, next_base};
      req_checksummed <= ck_fmt;
    end
  end

  // one-cycle verdict pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      req_done <= 1'b0;
      req_execute <= 1'b0;
    end else begin
      req_done <= msg_end;
      // failed requests are never acted on
      req_execute <= msg_end && (next_req == REQ_OK) && (next_base == CTL_OK);
    end
  end

  // response character index
  always_ff @(posedge clk) begin
    if (srst || state != ST_EMIT) begin
      emit_idx <= 2'h0;
    end else if (buf_in_ready) begin
      emit_idx <= emit_idx + 2'h1;
    end
  end

  // four status characters, high digit first
  always_comb begin
    emit_char = 8'h00;
    case (emit_idx)
      2'h0: emit_char = hex_char(req_status[7:4]);
      2'h1: emit_char = hex_char(req_status[3:0]);
      2'h2: emit_char = hex_char(ctl_status[7:4]);
      2'h3: emit_char = hex_char(ctl_status[3:0]);
      default: emit_char = 8'h00;
    endcase
  end

  // buffer absorbs transmitter stalls without losing characters
  alsc_buf u_buf (
    .clk(clk),
    .srst(srst),
    .in_data(emit_char),
    .in_valid(state == ST_EMIT),
    .in_ready(buf_in_ready),
    .out_data(tx_char),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );
endmodule

// ---- alsc_pkg.sv ----
// constants for the ascii link status / checksum block
// assumes an 8-bit character stream from a uart on the same clock
// Summary of operation
// - request status 00 when request processed
// - request status 01 on bad format
// - request status 02 on unsupported operation
// - request status 04 on checksum or parity
// - every response carries a controller status code
// - controller status 00 when healthy and received
// - controller status 01 on invalid data, no action
// - controller status 02 while database change busy
// - controller status 04 on illegal state or mode
// - controller status 06 while auto tuning runs
// - controller status 07 when temporarily unable
// - status-change events add 80 to controller code
// - host writing parameter 255 clears change flag
// - optional checksum verifies request messages
// - 8-bit sum before checksum, high nibble first
// - checksum mismatch discards request, answers 04
// - message ends with cr then lf
package alsc_pkg;
  // request message status codes
  localparam logic [7:0] REQ_OK = 8'h00;
  localparam logic [7:0] REQ_FORMAT = 8'h01;
  localparam logic [7:0] REQ_UNSUPPORTED = 8'h02;
  localparam logic [7:0] REQ_CHECKSUM = 8'h04;
  // controller status base codes
  localparam logic [6:0] CTL_OK = 7'h00;
  localparam logic [6:0] CTL_BAD_DATA = 7'h01;
  localparam logic [6:0] CTL_BUSY = 7'h02;
  localparam logic [6:0] CTL_ILLEGAL = 7'h04;
  localparam logic [6:0] CTL_TUNING = 7'h06;
  localparam logic [6:0] CTL_UNABLE = 7'h07;
  // position of the status-change flag in the controller byte (adds 80)
  localparam int CTL_FLAG_BIT = 7;
  // number of status-change event sources
  localparam int EVT_W = 8;
  // ascii characters of interest, parity bit stripped
  localparam logic [6:0] CH_CR = 7'h0d;
  localparam logic [6:0] CH_LF = 7'h0a;
  localparam logic [6:0] CH_COMMA = 7'h2c;
  localparam logic [6:0] CH_SPACE = 7'h20;
  localparam logic [6:0] CH_DEL = 7'h7f;
  // checksum format identifier "4204", first character in top bits
  localparam logic [27:0] FMT_CKSUM = {7'h34, 7'h32, 7'h30, 7'h34};
  // field index that carries the format identifier
  localparam logic [3:0] FMT_FIELD = 4'h1;
  // fewest commas in a well formed request
  localparam logic [3:0] MIN_COMMAS = 4'h2;
  // longest request accepted, characters before cr
  localparam logic [6:0] MSG_MAX = 7'h50;
  // index of the last response character in an answer (four per answer)
  localparam logic [1:0] RESP_LAST = 2'h3;
  // reset values
  localparam logic [7:0] SUM_RST = 8'h00;
  localparam logic [6:0] LEN_RST = 7'h00;
  // buffer depth
  localparam int BUF_DEPTH = 2;
endpackage

// ---- alsc_buf.sv ----
// two-entry buffer between response builder and transmitter
// assumes both sides on clk; out side may stall for any time
`timescale 1ns/1ps
module alsc_buf
  import alsc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  // storage, entry 0 is the head
  logic [7:0] mem [BUF_DEPTH];
  // words held, 0..2
  logic [1:0] count;
  logic push;
  logic pop;

  // honest full and empty
  assign in_ready = (count != 2'(BUF_DEPTH));
  assign out_valid = (count != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[0];

  // occupancy
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= 2'h0;
    end else begin
      count <= count + 2'(push) - 2'(pop);
    end
  end

  // shift on pop, write at the first free slot
  always_ff @(posedge clk) begin
    if (srst) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
    end else begin
      if (pop) begin
        mem[0] <= mem[1];
      end
      if (push) begin
        // slot depends on whether the head leaves this cycle
        if (count == 2'h0 || (count == 2'h1 && pop)) begin
          mem[0] <= in_data;
        end else begin
          mem[1] <= in_data;
        end
      end
    end
  end
endmodule

// ---- alsc_core_properties.sv ----
// port checks for the status / checksum core
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
module alsc_core_properties
  import alsc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rx_ready,
  input wire logic [EVT_W-1:0] change_evt,
  input wire logic change_clear,
  input wire logic req_done,
  input wire logic req_execute,
  input wire logic [7:0] req_status,
  input wire logic [7:0] ctl_status,
  input wire logic change_flag,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  // one domain, so default clock and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_done_single: assert property (req_done |=> !req_done)
    else $error("done pulse too long");
  a_exec_when_ok: assert property (req_execute |-> req_done && req_status == 8'h00 && ctl_status[6:0] == 7'h00)
    else $error("execute without clean status");
  a_req_code_set: assert property (req_done |-> req_status inside {8'h00, 8'h01, 8'h02, 8'h04})
    else $error("bad request code");
  a_ctl_code_set: assert property (req_done |-> ctl_status[6:0] inside {7'h00, 7'h01, 7'h02, 7'h04, 7'h06, 7'h07})
    else $error("bad controller code");
  a_flag_in_code: assert property (req_done |-> ctl_status[7] == $past(change_flag))
    else $error("flag not in code");
  a_flag_sets: assert property (|change_evt |=> change_flag)
    else $error("flag not set");
  a_flag_clears: assert property (change_clear && change_evt == '0 |=> !change_flag)
    else $error("flag not cleared");
  a_flag_sticky: assert property (!change_clear && change_evt == '0 |=> $stable(change_flag))
    else $error("flag moved alone");
  a_resp_queued: assert property (req_done |-> !rx_ready ##1 tx_valid)
    else $error("response not queued");
  a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
    else $error("stalled char lost");
  a_ready_back: assert property (req_done |-> ##[1:200] rx_ready)
    else $error("receiver stuck");
endmodule

// ---- alsc_host_sink.sv ----
// host side model: takes response chars, stalls when slow
// assumes the core's tx handshake on the same clock
`timescale 1ns/1ps
module alsc_host_sink
(
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$]; // chars taken, read by the bench
  // host keeps every char it accepts
  always @(posedge clk) begin
    if (!srst && tx_valid && tx_ready) got.push_back(tx_char);
    // a slow host stalls about half the cycles
    tx_ready <= !srst && (!slow || 1'($urandom));
  end
endmodule

// ---- testbench.sv ----
// self-checking bench for the status / checksum core
// assumes four hex status chars answer each request
`timescale 1ns/1ps
module testbench
  import alsc_pkg::*;
;
  logic clk, srst, rx_valid, rx_perr, rx_ready, change_clear, slow;
  logic req_done, req_execute, req_ck, change_flag, tx_valid, tx_ready;
  logic [7:0] rx_char, req_status, ctl_status, tx_char;
  logic [EVT_W-1:0] change_evt;
  logic [5:0] lvl; // unable, tuning, illegal, busy, invalid, unsupported
  logic mflag; // model of the sticky flag
  int errors, checked, dones;

  alsc_core dut_u (.clk(clk), .srst(srst), .rx_char(rx_char), .rx_valid(rx_valid),
    .rx_parity_err(rx_perr), .rx_ready(rx_ready), .op_unsupported(lvl[0]),
    .data_invalid(lvl[1]), .db_busy(lvl[2]), .state_illegal(lvl[3]),
    .tuning_active(lvl[4]), .unable_now(lvl[5]), .change_evt(change_evt),
    .change_clear(change_clear), .req_done(req_done), .req_execute(req_execute),
    .req_checksummed(req_ck), .req_status(req_status), .ctl_status(ctl_status),
    .change_flag(change_flag), .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready));
  alsc_host_sink sink_u (.clk(clk), .srst(srst), .slow(slow), .tx_char(tx_char),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (req_done === 1'b1) dones++;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // 8-bit sum, parity bit dropped
  function automatic logic [7:0] cksum(input string s);
    logic [7:0] a;
    a = 8'h00;
    foreach (s[i]) a = a + {1'b0, s[i][6:0]};
    return a;
  endfunction
  function automatic logic [7:0] exp_req(input bit pe, input bit fm, input bit cb, input bit un);
    if (pe) return 8'h04;
    if (fm) return 8'h01;
    if (cb) return 8'h04;
    return un ? 8'h02 : 8'h00;
  endfunction
  // highest set level wins
  function automatic logic [7:0] exp_ctl(input logic [5:0] l, input logic f);
    logic [6:0] c[6] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h06, 7'h07};
    logic [6:0] b;
    b = 7'h00;
    for (int i = 1; i < 6; i++) if (l[i]) b = c[i];
    return {f, b};
  endfunction
  // hold each char until it is taken
  task automatic send(input string m, input int perr_at);
    byte c;
    for (int i = 0; i < m.len(); i++) begin
      c = m[i];
      rx_char <= {1'($urandom), c[6:0]};
      rx_valid <= 1'b1;
      rx_perr <= (i == perr_at);
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_perr <= 1'b0;
  endtask
  // ck: 0 none, 1 good sum, 2 bad sum, 3 sum already in body
  task automatic request(input string body, input int ck, input int perr_at,
                         input logic [5:0] l, input bit fmt);
    string m, r;
    logic [7:0] er, ec;
    int n;
    m = body;
    if (ck == 1 || ck == 2) m = {body, $sformatf("%02X", cksum(body) + 8'(ck - 1))};
    er = exp_req(perr_at >= 0, fmt, ck == 2, l[0]);
    ec = exp_ctl(l, mflag);
    r = {$sformatf("%02X", er), $sformatf("%02X", ec)};
    lvl <= l;
    send({m, "\r\n"}, perr_at);
    // verdict pulse stands only in the cycle after the lf edge
    #1;
    check("req_done", {7'h00, req_done}, 8'h01);
    check("req_status", req_status, er);
    check("ctl_status", ctl_status, ec);
    check("req_execute", {7'h00, req_execute}, {7'h00, er == 8'h00 && ec[6:0] == 7'h00});
    check("req_checksummed", {7'h00, req_ck}, {7'h00, ck != 0});
    n = 0;
    while (sink_u.got.size() < 4 && n < 300) begin
      @(posedge clk);
      n++;
    end
    for (int i = 0; i < 4; i++) check("resp_char", sink_u.got[i], r[i]);
    sink_u.got.delete();
  endtask
  task automatic pulse(input logic [EVT_W-1:0] e, input logic c);
    change_evt <= e;
    change_clear <= c;
    @(posedge clk);
    change_evt <= '0;
    change_clear <= 1'b0;
    @(posedge clk);
    mflag = (e != '0) ? 1'b1 : (c ? 1'b0 : mflag);
    check("change_flag", {7'h00, change_flag}, {7'h00, mflag});
  endtask

  initial begin
    string b;
    int ck, pa;
    logic [5:0] l;
    srst = 1'b1;
    rx_char = 8'h00;
    rx_valid = 1'b0;
    rx_perr = 1'b0;
    lvl = 6'h00;
    change_evt = '0;
    change_clear = 1'b0;
    slow = 1'b0;
    mflag = 1'b0;
    void'($urandom(21));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    check("cksum", cksum("03,4204,E4,18,001,"), 8'h7c);
    request("03,4204,E4,18,001,7c", 3, -1, 6'h00, 0);
    request("02,1,001", 0, -1, 6'h00, 0);
    request("03,4204,E4,18,001,", 2, -1, 6'h00, 0);
    request("02,1,001", 0, 3, 6'h00, 0);
    request("02,1", 0, -1, 6'h00, 1);
    request("02,\t1,001", 0, -1, 6'h00, 1);
    request({"02,1,", {75{"0"}}}, 0, -1, 6'h00, 0);
    request({"02,1,", {76{"0"}}}, 0, -1, 6'h00, 1);
    for (int i = 0; i < 6; i++) request("02,1,001", 0, -1, 6'h01 << i, 0);
    request("02,1,001", 0, -1, 6'h3f, 0);
    pa = dones;
    send("02,1,001\rX", -1);
    repeat (4) @(posedge clk);
    check("discard", 8'(dones - pa), 8'h00);
    // random traffic with flag events and host stalls
    for (int k = 0; k < 40; k++) begin
      slow <= 1'($urandom);
      pulse(EVT_W'(1 << $urandom_range(7, 0)) & {EVT_W{1'($urandom)}}, 1'($urandom));
      ck = $urandom_range(2, 0);
      if (ck != 0) b = $sformatf("%02d,4204,%03d,", k, $urandom_range(999, 0));
      else b = $sformatf("%02d,1,%03d", k, $urandom_range(999, 0));
      pa = ($urandom_range(9, 0) == 0) ? $urandom_range(b.len() - 1, 0) : -1;
      l = 6'($urandom) & {6{1'($urandom)}};
      request(b, ck, pa, l, 0);
    end
    stop_test();
  end
  // watchdog well past the expected run
  initial begin
    #(20 * 40000);
    errors++;
    stop_test();
  end
endmodule

bind alsc_core alsc_core_properties chk_u (.clk(clk), .srst(srst), .rx_ready(rx_ready),
  .change_evt(change_evt), .change_clear(change_clear), .req_done(req_done),
  .req_execute(req_execute), .req_status(req_status), .ctl_status(ctl_status),
  .change_flag(change_flag), .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready));
